// ===== rtl/pwr_save_pkg.sv
package pwr_save_pkg;

	// register indices on the plain register port
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
	localparam logic [7:0] ADDR_WAKE_CONTROL = 8'h91;

	// power_control fields
	localparam int BIT_IDLE = 0;
	localparam int BIT_STOP = 1;
	// wake_control fields
	localparam int BIT_REF_KEEP = 0;
	localparam int BIT_FAST_SEL = 1;
	localparam int BIT_FAST_ACTIVE = 2;

	localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;

	// crystal start-up: counted in external crystal clocks
	localparam int XTAL_START_CYCLES = 65536;
	localparam logic [16:0] XTAL_START_LAST = 17'(XTAL_START_CYCLES - 1);
	localparam logic [16:0] COUNT_ZERO = 17'h0_0000;

	typedef enum logic [2:0] {
		MODE_RUN,
		MODE_IDLE,
		MODE_STOP,
		MODE_XTAL_WAIT,
		MODE_FAST_RUN
	} power_mode_t;

	typedef struct packed {
		logic addr_latch_strobe;
		logic program_store_strobe;
		logic [7:0] port_zero_out;
		logic [7:0] port_zero_oe;
		logic [7:0] port_two_out;
		logic [7:0] port_two_oe;
		logic port_two_weak;
	} bus_pins_t;

	typedef struct packed {
		logic [7:0] port_zero;
		logic [7:0] port_two;
		logic [7:0] next_opcode;
		logic [7:0] next_addr_high;
		logic external_program;
	} bus_source_t;

endpackage

// ===== rtl/idle_stop_power_controller.sv
// Summary of operation
// - setting idle bit freezes program counter after the setting instruction; in fast-oscillator run the bit clears but idle is not entered
// - idle keeps all clocks running; any interrupt can end idle
// - enabled interrupt in idle vectors and clears idle bit in hardware
// - return_from_interrupt resumes after the instruction that entered saving
// - any reset ends idle; restart with no added delay
// - watchdog keeps counting in idle; software must service it
// - stop bit halts processor and stops all on-chip clocks
// - crystal drive amplifier disabled in stop
// - only non-clocked interrupts wake stop; clocked ones ignored
// - power-fail interrupt wakes stop only with reference keep set
// - stop interrupt wake fetches that interrupt's vector
// - external reset always ends stop; watchdog reset never acts in stop
// - supply dip in stop resets only when reference keep is set
// - power-on reset always acts, restarting at 0000h
// - without fast oscillator select, wait 65,536 crystal cycles after stop
// - same start-up count with an external oscillator module
// - in idle/stop strobes high; internal execution drives port registers
// - port zero showing its register acts as open drain
// - external execution idle: port zero drives opcode, port two address high
// - external execution stop: port two through weak pull-ups only
// - fast oscillator select: run at once, switch to crystal after 65,536 cycles
// - re-entering stop on fast oscillator stops both oscillators
// - fast_osc_active set while fast oscillator clocks, clear on crystal
// - only power-on reset clears fast oscillator select
// - stop bit is bit 1 of power_control
module idle_stop_power_controller
	import pwr_save_pkg::*;
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// reset sources, asynchronous to the core
	input wire logic por_in,
	input wire logic ext_reset_pin_in,
	input wire logic supply_dip_in,
	input wire logic watchdog_reset_in,
	// crystal clock ticks while the amplifier runs
	input wire logic xtal_tick_in,
	// interrupt logic
	input wire logic irq_pending_in,
	input wire logic irq_clocked_in,
	input wire logic irq_power_fail_in,
	input wire logic [15:0] irq_vector_in,
	// cpu core
	input wire logic instr_done_in,
	input wire logic [15:0] return_addr_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// bus pin sources
	input wire bus_source_t bus_src_in,
	// core control
	output logic cpu_hold_out,
	output logic core_reset_out,
	output logic vector_take_out,
	output logic [15:0] vector_addr_out,
	output logic [15:0] resume_addr_out,
	output logic periph_clk_en_out,
	output logic xtal_amp_en_out,
	output logic fast_osc_en_out,
	output logic clk_sel_fast_out,
	// pins
	output bus_pins_t pins_out
);

	power_mode_t mode;
	logic [7:0] power_control;
	logic ref_keep;
	logic fast_sel;
	logic [16:0] xtal_count;
	logic [1:0] por_sync, ext_sync, dip_sync, wd_sync;
	logic [1:0] xtal_sync;
	logic xtal_seen;
	logic idle_req, stop_req, reset_any, stop_wake, irq_stop_ok;

	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] target);
		return a == target;
	endfunction

	// open drain and weak pull-up both actively pull only the zeros
	function automatic logic [7:0] low_drive(input logic [7:0] v);
		return ~v;
	endfunction

	// asynchronous pins pass two flops before use
	// the edge history resets low, matching the crystal pin at rest
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			por_sync <= 2'h0;
			ext_sync <= 2'h0;
			dip_sync <= 2'h0;
			wd_sync <= 2'h0;
			xtal_sync <= 2'h0;
			xtal_seen <= 1'b0;
		end else begin
			por_sync <= {por_sync[0], por_in};
			ext_sync <= {ext_sync[0], ext_reset_pin_in};
			dip_sync <= {dip_sync[0], supply_dip_in};
			wd_sync <= {wd_sync[0], watchdog_reset_in};
			xtal_sync <= {xtal_sync[0], xtal_tick_in};
			xtal_seen <= xtal_sync[1];
		end
	end

	logic xtal_edge;
	assign xtal_edge = xtal_sync[1] & ~xtal_seen;

	logic in_stop;
	assign in_stop = (mode == MODE_STOP);

	// shared views of the mode, read by several outputs
	logic in_idle, in_fast, in_xtal_wait;
	assign in_idle = (mode == MODE_IDLE);
	assign in_fast = (mode == MODE_FAST_RUN);
	assign in_xtal_wait = (mode == MODE_XTAL_WAIT);

	// start-up count ends on the edge that brings it to the full count
	logic xtal_done;
	assign xtal_done = xtal_edge && (xtal_count == XTAL_START_LAST);

	// resets: watchdog has no clock in stop, dip only with reference kept
	// with the reference off no monitor runs, so a dip in stop goes unseen
	always_comb begin
		reset_any = por_sync[1] | ext_sync[1];
		if (in_stop) begin
			reset_any = reset_any | (dip_sync[1] & ref_keep);
		end else begin
			reset_any = reset_any | dip_sync[1] | wd_sync[1];
		end
	end

	// only unclocked sources reach the wake path in stop
	// power-fail needs the monitor alive, hence reference keep as well
	assign irq_stop_ok = irq_pending_in & ~irq_clocked_in
		& (~irq_power_fail_in | ref_keep);
	assign stop_wake = in_stop & irq_stop_ok;

	// mode requests taken when the setting instruction completes
	assign stop_req = power_control[BIT_STOP] & instr_done_in;
	assign idle_req = power_control[BIT_IDLE] & ~power_control[BIT_STOP]
		& instr_done_in;

	// the status bit of wake_control has no flop behind it; writes to it drop
	logic wr_pc, wr_wc;
	assign wr_pc = reg_wr_in & reg_hit(reg_addr_in, ADDR_POWER_CONTROL);
	assign wr_wc = reg_wr_in & reg_hit(reg_addr_in, ADDR_WAKE_CONTROL);

	logic wake_vector;
	assign wake_vector = ((mode == MODE_IDLE) & irq_pending_in) | stop_wake;

	// a crystal wake must not let the core fetch before the start-up count ends
	logic take_now;
	assign take_now = (wake_vector & ~(stop_wake & ~fast_sel))
		| (in_xtal_wait & xtal_done);

	// power_control: a software write in the wake cycle wins over the clear
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			power_control <= POWER_CONTROL_RESET;
		end else if (reset_any) begin
			power_control <= POWER_CONTROL_RESET;
		end else if (wr_pc) begin
			power_control <= reg_wdata_in;
		end else if (wake_vector) begin
			power_control[BIT_IDLE] <= 1'b0;
			power_control[BIT_STOP] <= 1'b0;
		end else if (idle_req | stop_req) begin
			// bits consumed as the request is taken, even in fast run where idle is not entered
			power_control[BIT_IDLE] <= 1'b0;
			power_control[BIT_STOP] <= 1'b0;
		end
	end

	// reference keep clears on any reset; select survives all but power-on
	// so a system woken by reset keeps its fast restart
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ref_keep <= 1'b0;
			fast_sel <= 1'b0;
		end else begin
			if (reset_any) begin
				ref_keep <= 1'b0;
			end else if (wr_wc) begin
				ref_keep <= reg_wdata_in[BIT_REF_KEEP];
			end
			if (por_sync[1]) begin
				fast_sel <= 1'b0;
			end else if (wr_wc) begin
				fast_sel <= reg_wdata_in[BIT_FAST_SEL];
			end
		end
	end

	// mode sequencer
	// any reset returns straight to run; the core is held by core_reset_out
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			mode <= MODE_RUN;
		end else if (reset_any) begin
			mode <= MODE_RUN;
		end else begin
			case (mode)
				MODE_RUN: begin
					if (stop_req) begin
						mode <= MODE_STOP;
					end else if (idle_req) begin
						mode <= MODE_IDLE;
					end
				end
				MODE_IDLE: begin
					if (irq_pending_in) begin
						mode <= MODE_RUN;
					end
				end
				MODE_STOP: begin
					if (stop_wake) begin
						mode <= fast_sel ? MODE_FAST_RUN : MODE_XTAL_WAIT;
					end
				end
				MODE_XTAL_WAIT: begin
					if (xtal_done) begin
						mode <= MODE_RUN;
					end
				end
				MODE_FAST_RUN: begin
					// a short task may stop again before the crystal settles
					if (stop_req) begin
						mode <= MODE_STOP;
					end else if (xtal_done) begin
						mode <= MODE_RUN;
					end
				end
				default: begin
					mode <= MODE_RUN;
				end
			endcase
		end
	end

	// crystal start-up count in crystal cycles, cleared on every stop entry
	// so a short wake never inherits a partial count from the previous one
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			xtal_count <= COUNT_ZERO;
		end else if (mode == MODE_XTAL_WAIT || mode == MODE_FAST_RUN) begin
			if (xtal_edge) begin
				xtal_count <= xtal_count + 17'h0_0001;
			end
		end else begin
			xtal_count <= COUNT_ZERO;
		end
	end

	// vector pulse and address to the core
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			vector_take_out <= 1'b0;
			vector_addr_out <= RESET_VECTOR;
		end else begin
			vector_take_out <= take_now & ~reset_any;
			if (reset_any) begin
				vector_addr_out <= RESET_VECTOR;
			end else if (wake_vector) begin
				// latched at wake; a crystal wake pulses vector_take_out only after start-up
				vector_addr_out <= irq_vector_in;
			end
		end
	end

	// return address taken as the setting instruction completes
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			resume_addr_out <= RESET_VECTOR;
		end else if (idle_req | stop_req) begin
			resume_addr_out <= return_addr_in;
		end
	end

	// core control
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cpu_hold_out <= 1'b0;
			core_reset_out <= 1'b1;
		end else begin
			core_reset_out <= reset_any;
			// hold covers the crystal wait: no fetch until the count completes
			cpu_hold_out <= in_idle | in_stop | in_xtal_wait;
		end
	end

	// peripheral clocks and crystal amplifier; both run in idle
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			periph_clk_en_out <= 1'b1;
			xtal_amp_en_out <= 1'b1;
		end else begin
			// watchdog stays clocked in idle; servicing is software's job
			periph_clk_en_out <= ~in_stop;
			xtal_amp_en_out <= ~in_stop;
		end
	end

	// fast oscillator: on only until the crystal has counted its start-up
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			fast_osc_en_out <= 1'b0;
			clk_sel_fast_out <= 1'b0;
		end else begin
			fast_osc_en_out <= in_fast;
			clk_sel_fast_out <= in_fast;
		end
	end

	// pin states while saving power
	logic saving;
	assign saving = (mode == MODE_IDLE) | in_stop;

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pins_out <= '0;
		end else if (saving) begin
			pins_out.addr_latch_strobe <= 1'b1;
			pins_out.program_store_strobe <= 1'b1;
			pins_out.port_two_weak <= 1'b0;
			if (bus_src_in.external_program && mode == MODE_IDLE) begin
				// external fetch in idle: the bus keeps showing the next opcode
				pins_out.port_zero_out <= bus_src_in.next_opcode;
				pins_out.port_zero_oe <= 8'hFF;
				pins_out.port_two_out <= bus_src_in.next_addr_high;
				pins_out.port_two_oe <= 8'hFF;
			end else begin
				// open drain: drive only the zeros
				pins_out.port_zero_out <= bus_src_in.port_zero;
				pins_out.port_zero_oe <= low_drive(bus_src_in.port_zero);
				pins_out.port_two_out <= bus_src_in.port_two;
				if (bus_src_in.external_program) begin
					// weak pull-ups: a one rises slowly once stop is entered
					pins_out.port_two_oe <= low_drive(bus_src_in.port_two);
					pins_out.port_two_weak <= 1'b1;
				end else begin
					pins_out.port_two_oe <= 8'hFF;
				end
			end
		end else begin
			// running: the core owns the bus, pins rest quiet here
			pins_out <= '0;
			pins_out.addr_latch_strobe <= 1'b1;
			pins_out.program_store_strobe <= 1'b1;
		end
	end

	// read data one cycle after the strobe; unmapped reads zero
	// cycles without a read show zero so stale data never lingers
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= READ_ZERO;
		end else if (reg_rd_in) begin
			if (reg_hit(reg_addr_in, ADDR_POWER_CONTROL)) begin
				reg_rdata_out <= power_control;
			end else if (reg_hit(reg_addr_in, ADDR_WAKE_CONTROL)) begin
				reg_rdata_out <= READ_ZERO;
				reg_rdata_out[BIT_REF_KEEP] <= ref_keep;
				reg_rdata_out[BIT_FAST_SEL] <= fast_sel;
				reg_rdata_out[BIT_FAST_ACTIVE] <= (mode == MODE_FAST_RUN);
			end else begin
				reg_rdata_out <= READ_ZERO;
			end
		end else begin
			reg_rdata_out <= READ_ZERO;
		end
	end

endmodule

// ===== verif/pwr_ctl_props.sv
module pwr_ctl_props
	import pwr_save_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic por_in,
	input wire logic ext_reset_pin_in,
	input wire logic supply_dip_in,
	input wire logic watchdog_reset_in,
	input wire logic irq_pending_in,
	input wire logic irq_clocked_in,
	input wire logic [15:0] irq_vector_in,
	input wire bus_source_t bus_src_in,
	input wire logic cpu_hold_out,
	input wire logic core_reset_out,
	input wire logic vector_take_out,
	input wire logic [15:0] vector_addr_out,
	input wire logic periph_clk_en_out,
	input wire logic xtal_amp_en_out,
	input wire logic fast_osc_en_out,
	input wire logic clk_sel_fast_out,
	input wire bus_pins_t pins_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	sequence s_wd_quiet;
		(!periph_clk_en_out && watchdog_reset_in && !ext_reset_pin_in && !por_in
			&& !supply_dip_in)[*4];
	endsequence
	property p_wd_stop; s_wd_quiet |-> !core_reset_out; endproperty
	property p_ext_stop;
		$rose(ext_reset_pin_in) && !periph_clk_en_out |-> ##[1:4] core_reset_out;
	endproperty
	property p_periph_amp; !periph_clk_en_out |-> !xtal_amp_en_out; endproperty
	property p_amp_both; !xtal_amp_en_out |-> !periph_clk_en_out && !fast_osc_en_out; endproperty
	property p_clocked;
		!xtal_amp_en_out && irq_pending_in && irq_clocked_in && !ext_reset_pin_in
			|=> !xtal_amp_en_out && !vector_take_out;
	endproperty
	property p_fast; clk_sel_fast_out |-> fast_osc_en_out; endproperty
	property p_strobe;
		cpu_hold_out && !core_reset_out
			|-> pins_out.addr_latch_strobe && pins_out.program_store_strobe;
	endproperty
	property p_vec; vector_take_out |-> vector_addr_out == $past(irq_vector_in); endproperty
	property p_wake_run; vector_take_out |-> ##1 !cpu_hold_out; endproperty
	property p_open_drain;
		cpu_hold_out && !bus_src_in.external_program
			|-> (pins_out.port_zero_oe & pins_out.port_zero_out) == 8'h00;
	endproperty
	a_wd_stop: assert property (p_wd_stop) else $error("watchdog reset acted in stop");
	a_ext_stop: assert property (p_ext_stop) else $error("external reset ignored");
	a_periph_amp: assert property (p_periph_amp) else $error("amplifier on in stop");
	a_amp_both: assert property (p_amp_both) else $error("oscillator left on");
	a_clocked: assert property (p_clocked) else $error("clocked irq left stop");
	a_fast: assert property (p_fast) else $error("fast clock selected while off");
	a_strobe: assert property (p_strobe) else $error("strobes low while saving");
	a_vec: assert property (p_vec) else $error("wrong wake vector");
	a_wake_run: assert property (p_wake_run) else $error("core held after vector");
	a_open_drain: assert property (p_open_drain) else $error("port zero drives high");
endmodule

bind idle_stop_power_controller pwr_ctl_props u_props (.mclk_in, .rst_in, .por_in,
	.ext_reset_pin_in, .supply_dip_in, .watchdog_reset_in, .irq_pending_in, .irq_clocked_in,
	.irq_vector_in, .bus_src_in, .cpu_hold_out, .core_reset_out, .vector_take_out,
	.vector_addr_out, .periph_clk_en_out, .xtal_amp_en_out, .fast_osc_en_out,
	.clk_sel_fast_out, .pins_out);

// ===== verif/cpu_core_model.sv
module cpu_core_model
	import pwr_save_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_addr_in,
	output logic instr_done_out,
	output logic [15:0] return_addr_out
);
	// the register write is the setting instruction; it completes one cycle on
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			instr_done_out <= 1'b0;
			return_addr_out <= 16'h0100;
		end else begin
			instr_done_out <= reg_wr_in && reg_addr_in == ADDR_POWER_CONTROL;
			if (reg_wr_in && reg_addr_in == ADDR_POWER_CONTROL) begin
				return_addr_out <= return_addr_out + 16'h0003;
			end
		end
	end
endmodule

// ===== verif/test_idle_stop_power_controller.sv
module test_idle_stop_power_controller
	import pwr_save_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_in = 0, rst_in = 1, por_in = 0, ext_reset_pin_in = 0, supply_dip_in = 0;
	logic watchdog_reset_in = 0, xtal_tick_in = 0, irq_pending_in = 0, irq_clocked_in = 0;
	logic irq_power_fail_in = 0, reg_wr_in = 0, reg_rd_in = 0;
	logic [15:0] irq_vector_in = 16'h0000;
	logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
	bus_source_t bus_src_in = {8'h5a, 8'hc3, 8'h12, 8'h34, 1'b0};
	logic instr_done_in, cpu_hold_out, core_reset_out, vector_take_out, periph_clk_en_out;
	logic xtal_amp_en_out, fast_osc_en_out, clk_sel_fast_out;
	logic [15:0] return_addr_in, vector_addr_out, resume_addr_out;
	bus_pins_t pins_out;
	int fails = 0, num_checks = 0;
	always #2 mclk_in = ~mclk_in;
	cpu_core_model core (.mclk_in, .rst_in, .reg_wr_in, .reg_addr_in,
		.instr_done_out(instr_done_in), .return_addr_out(return_addr_in));
	idle_stop_power_controller dut (.mclk_in, .rst_in, .por_in, .ext_reset_pin_in,
		.supply_dip_in, .watchdog_reset_in, .xtal_tick_in, .irq_pending_in, .irq_clocked_in,
		.irq_power_fail_in, .irq_vector_in, .instr_done_in, .return_addr_in, .reg_addr_in,
		.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .bus_src_in, .cpu_hold_out,
		.core_reset_out, .vector_take_out, .vector_addr_out, .resume_addr_out,
		.periph_clk_en_out, .xtal_amp_en_out, .fast_osc_en_out, .clk_sel_fast_out, .pins_out);
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		#1 chk("read", 16'(exp), 16'(reg_rdata_out));
	endtask
	task wait_take();
		int i;
		i = 0;
		while (vector_take_out !== 1'b1 && i < 60) begin
			cyc(1);
			i++;
		end
		chk("take", 16'h0001, 16'(vector_take_out));
	endtask
	task idle_wake();
		rd(ADDR_POWER_CONTROL, POWER_CONTROL_RESET);
		wr(8'h55, 8'hff);
		rd(8'h55, READ_ZERO);
		wr(ADDR_POWER_CONTROL, 8'h01);
		cyc(4);
		chk("hold", 16'h0001, 16'(cpu_hold_out));
		chk("periph", 16'h0001, 16'(periph_clk_en_out));
		chk("strobes", 16'h0003,
			16'({pins_out.addr_latch_strobe, pins_out.program_store_strobe}));
		chk("port_two", 16'(bus_src_in.port_two), 16'(pins_out.port_two_out));
		chk("p0_oe", {8'h00, ~bus_src_in.port_zero}, 16'(pins_out.port_zero_oe));
		@(posedge mclk_in);
		irq_vector_in <= 16'h0013;
		irq_pending_in <= 1'b1;
		wait_take();
		chk("vector", 16'h0013, vector_addr_out);
		chk("resume", return_addr_in, resume_addr_out);
		@(posedge mclk_in);
		irq_pending_in <= 1'b0;
		cyc(2);
		chk("hold", 16'h0000, 16'(cpu_hold_out));
		rd(ADDR_POWER_CONTROL, 8'h00);
	endtask
	task stop_fast();
		wr(ADDR_WAKE_CONTROL, 8'h02);
		wr(ADDR_POWER_CONTROL, 8'h03);
		cyc(4);
		chk("amp", 16'h0000, 16'(xtal_amp_en_out));
		chk("periph", 16'h0000, 16'(periph_clk_en_out));
		@(posedge mclk_in);
		irq_clocked_in <= 1'b1;
		irq_pending_in <= 1'b1;
		irq_vector_in <= 16'h0023;
		cyc(10);
		chk("amp", 16'h0000, 16'(xtal_amp_en_out));
		@(posedge mclk_in);
		irq_clocked_in <= 1'b0;
		irq_vector_in <= 16'h0003;
		wait_take();
		chk("vector", 16'h0003, vector_addr_out);
		cyc(1);
		chk("fast_sel", 16'h0001, 16'(clk_sel_fast_out));
		chk("hold", 16'h0000, 16'(cpu_hold_out));
		@(posedge mclk_in);
		irq_pending_in <= 1'b0;
		rd(ADDR_WAKE_CONTROL, 8'h06);
		wr(ADDR_POWER_CONTROL, 8'h02);
		cyc(4);
		chk("fast_osc", 16'h0000, 16'(fast_osc_en_out));
		chk("amp", 16'h0000, 16'(xtal_amp_en_out));
	endtask
	task stop_resets();
		@(posedge mclk_in);
		watchdog_reset_in <= 1'b1;
		cyc(8);
		chk("wd_reset", 16'h0000, 16'(core_reset_out));
		@(posedge mclk_in);
		watchdog_reset_in <= 1'b0;
		supply_dip_in <= 1'b1;
		cyc(8);
		chk("dip_reset", 16'h0000, 16'(core_reset_out));
		@(posedge mclk_in);
		supply_dip_in <= 1'b0;
		ext_reset_pin_in <= 1'b1;
		cyc(4);
		chk("ext_reset", 16'h0001, 16'(core_reset_out));
		@(posedge mclk_in);
		ext_reset_pin_in <= 1'b0;
		cyc(6);
		chk("vector", RESET_VECTOR, vector_addr_out);
		rd(ADDR_WAKE_CONTROL, 8'h02);
		@(posedge mclk_in);
		por_in <= 1'b1;
		cyc(4);
		chk("por_reset", 16'h0001, 16'(core_reset_out));
		chk("por_vector", RESET_VECTOR, vector_addr_out);
		@(posedge mclk_in);
		por_in <= 1'b0;
		cyc(4);
		rd(ADDR_WAKE_CONTROL, READ_ZERO);
	endtask
	task idle_ext();
		@(posedge mclk_in);
		bus_src_in.external_program <= 1'b1;
		wr(ADDR_POWER_CONTROL, 8'h01);
		cyc(4);
		chk("p0_out", 16'(bus_src_in.next_opcode), 16'(pins_out.port_zero_out));
		chk("p0_oe", 16'h00ff, 16'(pins_out.port_zero_oe));
		chk("p2_out", 16'(bus_src_in.next_addr_high), 16'(pins_out.port_two_out));
		@(posedge mclk_in);
		irq_vector_in <= 16'h0013;
		irq_pending_in <= 1'b1;
		wait_take();
		@(posedge mclk_in);
		irq_pending_in <= 1'b0;
	endtask
	task xtal_wait();
		wr(ADDR_WAKE_CONTROL, 8'h00);
		cyc(40);
		wr(ADDR_POWER_CONTROL, 8'h02);
		cyc(3);
		chk("p2_weak", 16'h0001, 16'(pins_out.port_two_weak));
		chk("p2_oe", {8'h00, ~bus_src_in.port_two}, 16'(pins_out.port_two_oe));
		chk("p0_oe", {8'h00, ~bus_src_in.port_zero}, 16'(pins_out.port_zero_oe));
		@(posedge mclk_in);
		irq_power_fail_in <= 1'b1;
		irq_pending_in <= 1'b1;
		cyc(6);
		chk("pf_amp", 16'h0000, 16'(xtal_amp_en_out));
		@(posedge mclk_in);
		irq_power_fail_in <= 1'b0;
		cyc(1);
		chk("take", 16'h0000, 16'(vector_take_out));
		repeat (200) @(posedge mclk_in) xtal_tick_in <= ~xtal_tick_in;
		#1 chk("hold", 16'h0001, 16'(cpu_hold_out));
		chk("amp", 16'h0001, 16'(xtal_amp_en_out));
	endtask
	task end_sim();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge mclk_in);
		rst_in <= 1'b0;
		idle_wake();
		stop_fast();
		stop_resets();
		idle_ext();
		xtal_wait();
		end_sim();
	end
	initial begin
		#20000;
		fails++;
		end_sim();
	end
endmodule
